// ===== hdl/fmb_port_ctrl.sv
// Port control: mailboxes, resets, replay, Port B width, offset method, direction
//
// Operation
// - Port B mailbox select routes access to mailbox
// - Port B read: mailbox or FIFO output register
// - Port B writes only fill B-to-A mailbox
// - A-to-B flag low on Port A mailbox write
// - A-to-B writes blocked while flag low
// - A-to-B flag high on Port B mailbox read
// - B-to-A flag low on Port B mailbox write
// - B-to-A writes blocked while flag low
// - B-to-A flag high on Port A mailbox read
// - Both flags high after main/flush reset
// - Main/flush resets zero pointers and Port B output
// - Main reset captures offset method, width, order
// - Mailbox reset clears B-to-A mailbox
// - Flush reset keeps captured configuration
// - Replay strobe rewinds read pointer to zero
// - Replay only outside fall-through mode
// - Width select: 9-bit or 18-bit bus
// - Serial offset load low selects serial
// - Port A direction high writes, drives off
// - Port B direction low writes, drives off
// - Port A mailbox select routes to mailbox
// - Access only on clock edge with enable
// - Mailbox width follows Port B width
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`default_nettype none
module fmb_port_ctrl #(
  parameter int unsigned DEPTH = 16
) (
  input  wire logic        i_clk_sys,              // System clock, 50 MHz
  input  wire logic        i_rst,                  // Synchronous reset, high
  input  wire logic        i_port_a_clk,           // Port A clock pin
  input  wire logic        i_port_b_clk,           // Port B clock pin
  input  wire logic        i_main_reset_n,         // Main reset pin, low
  input  wire logic        i_mailbox_reset_n,      // B-to-A mailbox reset pin, low
  input  wire logic        i_flush_reset_n,        // Flush reset pin, low
  input  wire logic        i_replay_strobe_n,      // Replay strobe pin, low
  input  wire logic        i_port_a_en,            // Port A enable
  input  wire logic        i_port_b_en,            // Port B enable
  input  wire logic        i_port_b_select_n,      // Port B select, low
  input  wire logic        i_port_a_dir,           // Port A: high write, low read
  input  wire logic        i_port_b_dir,           // Port B: low write, high read
  input  wire logic        i_port_a_mailbox_sel,   // Port A mailbox select
  input  wire logic        i_port_b_mailbox_sel,   // Port B mailbox select
  input  wire logic        i_width_match_en,       // Width matching enable
  input  wire logic        i_bus_size_sel,         // High byte bus, low word bus
  input  wire logic        i_byte_order_sel,       // Byte order / fall-through mode
  input  wire logic        i_serial_offset_load_n, // Low selects serial offset load
  input  wire logic [1:0]  i_offset_sel,           // Default offset select
  input  wire logic [35:0] i_port_a_data,          // Port A data in
  input  wire logic [35:0] i_port_b_data,          // Port B data in
  output logic      [35:0] o_port_a_data,          // Port A data out
  output logic             o_port_a_data_oe,       // Port A output enable
  output logic      [35:0] o_port_b_data,          // Port B data out
  output logic             o_port_b_data_oe,       // Port B output enable
  output logic             o_a_to_b_mail_full_n,   // A-to-B mailbox flag
  output logic             o_b_to_a_mail_full_n,   // B-to-A mailbox flag
  output logic             o_fifo_empty_n,         // FIFO holds data
  output logic             o_fifo_full_n,          // FIFO has room
  input  wire logic [3:0]  i_avs_address,          // Avalon byte address
  input  wire logic        i_avs_read,             // Avalon read
  input  wire logic        i_avs_write,            // Avalon write
  input  wire logic [31:0] i_avs_writedata,        // Avalon write data
  input  wire logic [3:0]  i_avs_byteenable,       // Avalon byte enables
  output logic      [31:0] o_avs_readdata,         // Avalon read data
  output logic             o_avs_waitrequest       // Avalon waitrequest
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned PW = AW + 1;
  localparam int unsigned SW = 91;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || PW > 16)
      $error("fmb_port_ctrl: DEPTH must be a power of two from 2 to 32768");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [SW-1:0] pins_s;
  logic          a_clk_s, b_clk_s, mrs_s, mbr_s, prs_s, rt_s;
  logic          a_en_s, b_en_s, b_sel_n_s, a_dir_s, b_dir_s, a_mbx_s, b_mbx_s;
  logic          bm_s, size_s, be_s, spm_s;
  logic [1:0]    fs_s;
  logic [35:0]   a_data_s, b_data_s;

  fmb_sync #(
    .W (SW)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   ({i_port_a_clk, i_port_b_clk, i_main_reset_n, i_mailbox_reset_n,
                 i_flush_reset_n, i_replay_strobe_n, i_port_a_en, i_port_b_en,
                 i_port_b_select_n, i_port_a_dir, i_port_b_dir, i_port_a_mailbox_sel,
                 i_port_b_mailbox_sel, i_width_match_en, i_bus_size_sel, i_byte_order_sel,
                 i_serial_offset_load_n, i_offset_sel, i_port_a_data, i_port_b_data}),
    .o_sync    (pins_s)
  );

  assign {a_clk_s, b_clk_s, mrs_s, mbr_s, prs_s, rt_s, a_en_s, b_en_s, b_sel_n_s,
          a_dir_s, b_dir_s, a_mbx_s, b_mbx_s, bm_s, size_s, be_s, spm_s, fs_s,
          a_data_s, b_data_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and decoded port cycles
  logic a_clk_q_r, a_clk_q_nxt;
  logic b_clk_q_r, b_clk_q_nxt;
  logic mrs_q_r, mrs_q_nxt;
  logic rt_q_r, rt_q_nxt;
  logic a_edge, b_edge, mrs_rise, rt_fall;
  logic a_acc, b_acc;
  logic a_mb_wr, a_mb_rd, a_fifo_wr;
  logic b_mb_wr, b_mb_rd, b_fifo_rd;
  logic soft_flush_r, soft_flush_nxt;
  logic flush_any, main_rst;

  always_comb begin
    a_clk_q_nxt = a_clk_s;
    b_clk_q_nxt = b_clk_s;
    mrs_q_nxt   = mrs_s;
    rt_q_nxt    = rt_s;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      a_clk_q_r <= 1'b0;
      b_clk_q_r <= 1'b0;
      mrs_q_r   <= 1'b1;
      // Synchroniser resets low, so no false strobe follows reset
      rt_q_r    <= 1'b0;
    end else begin
      a_clk_q_r <= a_clk_q_nxt;
      b_clk_q_r <= b_clk_q_nxt;
      mrs_q_r   <= mrs_q_nxt;
      rt_q_r    <= rt_q_nxt;
    end
  end

  assign a_edge    = a_clk_s & ~a_clk_q_r;
  assign b_edge    = b_clk_s & ~b_clk_q_r;
  assign mrs_rise  = mrs_s & ~mrs_q_r;
  assign rt_fall   = ~rt_s & rt_q_r;
  assign main_rst  = ~mrs_s;
  assign flush_any = main_rst | ~prs_s | soft_flush_r;
  // Port cycles need a rising port clock and the port enable
  assign a_acc     = a_edge & a_en_s & ~flush_any;
  assign b_acc     = b_edge & b_en_s & ~b_sel_n_s & ~flush_any;
  assign a_mb_wr   = a_acc & a_dir_s & a_mbx_s;
  assign a_mb_rd   = a_acc & ~a_dir_s & a_mbx_s;
  assign a_fifo_wr = a_acc & a_dir_s & ~a_mbx_s;
  assign b_mb_wr   = b_acc & ~b_dir_s & b_mbx_s;
  assign b_mb_rd   = b_acc & b_dir_s & b_mbx_s;
  assign b_fifo_rd = b_acc & b_dir_s & ~b_mbx_s;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration captured at the end of a main reset
  logic       cfg_spm_n_r, cfg_spm_n_nxt;
  logic [1:0] cfg_fs_r, cfg_fs_nxt;
  logic       cfg_bm_r, cfg_bm_nxt;
  logic       cfg_size_r, cfg_size_nxt;
  logic       cfg_be_r, cfg_be_nxt;
  logic [1:0] bw_code;
  logic [35:0] bw_mask;
  logic [7:0] def_ofs;
  logic       fall_through_mode;

  // Flush reset never touches these
  always_comb begin
    cfg_spm_n_nxt = cfg_spm_n_r;
    cfg_fs_nxt    = cfg_fs_r;
    cfg_bm_nxt    = cfg_bm_r;
    cfg_size_nxt  = cfg_size_r;
    cfg_be_nxt    = cfg_be_r;
    if (mrs_rise) begin
      cfg_spm_n_nxt = spm_s;
      cfg_fs_nxt    = fs_s;
      cfg_bm_nxt    = bm_s;
      cfg_size_nxt  = size_s;
      cfg_be_nxt    = be_s;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cfg_spm_n_r <= 1'b1;
      cfg_fs_r    <= fmb_pkg::SEL_PAR;
      cfg_bm_r    <= 1'b0;
      cfg_size_r  <= 1'b0;
      cfg_be_r    <= 1'b0;
    end else begin
      cfg_spm_n_r <= cfg_spm_n_nxt;
      cfg_fs_r    <= cfg_fs_nxt;
      cfg_bm_r    <= cfg_bm_nxt;
      cfg_size_r  <= cfg_size_nxt;
      cfg_be_r    <= cfg_be_nxt;
    end
  end

  // Width select is assumed static, so the live pin is used with the enable
  always_comb begin
    if (!cfg_bm_r)
      bw_code = fmb_pkg::BW_LONG;
    else if (size_s)
      bw_code = fmb_pkg::BW_BYTE;
    else
      bw_code = fmb_pkg::BW_WORD;
    case (bw_code)
      fmb_pkg::BW_BYTE: bw_mask = fmb_pkg::MASK_BYTE;
      fmb_pkg::BW_WORD: bw_mask = fmb_pkg::MASK_WORD;
      default:          bw_mask = fmb_pkg::MASK_LONG;
    endcase
    if (!cfg_spm_n_r)
      def_ofs = fmb_pkg::OFS_NONE;
    else begin
      case (cfg_fs_r)
        fmb_pkg::SEL_PAR: def_ofs = fmb_pkg::OFS_NONE;
        fmb_pkg::SEL_8:   def_ofs = fmb_pkg::OFS_8;
        fmb_pkg::SEL_16:  def_ofs = fmb_pkg::OFS_16;
        default:          def_ofs = fmb_pkg::OFS_64;
      endcase
    end
  end

  // The order pin doubles as the timing mode once out of main reset
  assign fall_through_mode = be_s & mrs_s;

  ////////////////////////////////////////////////////////////////////////////
  // Main reset length check: four edges of each port clock
  logic [2:0] rst_a_cnt_r, rst_a_cnt_nxt;
  logic [2:0] rst_b_cnt_r, rst_b_cnt_nxt;
  logic       rst_ok_r, rst_ok_nxt;

  always_comb begin
    rst_a_cnt_nxt = rst_a_cnt_r;
    rst_b_cnt_nxt = rst_b_cnt_r;
    rst_ok_nxt    = rst_ok_r;
    if (main_rst) begin
      if (a_edge && rst_a_cnt_r != fmb_pkg::RST_EDGES)
        rst_a_cnt_nxt = rst_a_cnt_r + 3'h1;
      if (b_edge && rst_b_cnt_r != fmb_pkg::RST_EDGES)
        rst_b_cnt_nxt = rst_b_cnt_r + 3'h1;
    end else begin
      rst_a_cnt_nxt = 3'h0;
      rst_b_cnt_nxt = 3'h0;
    end
    if (mrs_rise)
      rst_ok_nxt = (rst_a_cnt_r == fmb_pkg::RST_EDGES) && (rst_b_cnt_r == fmb_pkg::RST_EDGES);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rst_a_cnt_r <= 3'h0;
      rst_b_cnt_r <= 3'h0;
      rst_ok_r    <= 1'b0;
    end else begin
      rst_a_cnt_r <= rst_a_cnt_nxt;
      rst_b_cnt_r <= rst_b_cnt_nxt;
      rst_ok_r    <= rst_ok_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mailboxes and their flags
  logic [35:0] a2b_mbx_r, a2b_mbx_nxt;
  logic [35:0] b2a_mbx_r, b2a_mbx_nxt;
  logic        a2b_full_n_r, a2b_full_n_nxt;
  logic        b2a_full_n_r, b2a_full_n_nxt;

  // A read and a write in one cycle leave the flag low only if it was high; a low flag blocks the write
  always_comb begin
    a2b_mbx_nxt    = a2b_mbx_r;
    b2a_mbx_nxt    = b2a_mbx_r;
    a2b_full_n_nxt = a2b_full_n_r;
    b2a_full_n_nxt = b2a_full_n_r;
    if (b_mb_rd)
      a2b_full_n_nxt = 1'b1;
    if (a_mb_wr && a2b_full_n_r) begin
      a2b_mbx_nxt    = a_data_s & bw_mask;
      a2b_full_n_nxt = 1'b0;
    end
    if (a_mb_rd)
      b2a_full_n_nxt = 1'b1;
    if (b_mb_wr && b2a_full_n_r) begin
      b2a_mbx_nxt    = b_data_s & bw_mask;
      b2a_full_n_nxt = 1'b0;
    end
    if (!mbr_s)
      b2a_mbx_nxt = fmb_pkg::DATA_ZERO;
    if (flush_any) begin
      a2b_full_n_nxt = 1'b1;
      b2a_full_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      a2b_mbx_r    <= fmb_pkg::DATA_ZERO;
      b2a_mbx_r    <= fmb_pkg::DATA_ZERO;
      a2b_full_n_r <= 1'b1;
      b2a_full_n_r <= 1'b1;
    end else begin
      a2b_mbx_r    <= a2b_mbx_nxt;
      b2a_mbx_r    <= b2a_mbx_nxt;
      a2b_full_n_r <= a2b_full_n_nxt;
      b2a_full_n_r <= b2a_full_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO pointers, storage and output registers
  logic [35:0]   mem_r [DEPTH];
  logic [PW-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [PW-1:0] fill;
  logic          fifo_empty, fifo_full;
  logic [35:0]   a_out_r, a_out_nxt;
  logic [35:0]   b_out_r, b_out_nxt;
  logic          a_oe_r, a_oe_nxt;
  logic          b_oe_r, b_oe_nxt;

  assign fill       = wr_ptr_r - rd_ptr_r;
  assign fifo_empty = (fill == '0);
  assign fifo_full  = (fill == PW'(DEPTH));

  always_comb begin
    rd_ptr_nxt = rd_ptr_r;
    wr_ptr_nxt = wr_ptr_r;
    a_out_nxt  = a_out_r;
    b_out_nxt  = b_out_r;
    a_oe_nxt   = ~a_dir_s;
    b_oe_nxt   = b_dir_s & ~b_sel_n_s;
    if (a_fifo_wr && !fifo_full)
      wr_ptr_nxt = wr_ptr_r + PW'(1);
    if (a_mb_rd)
      a_out_nxt = b2a_mbx_r;
    if (b_mb_rd)
      b_out_nxt = a2b_mbx_r;
    else if (b_fifo_rd && !fifo_empty) begin
      b_out_nxt  = mem_r[rd_ptr_r[AW-1:0]] & bw_mask;
      rd_ptr_nxt = rd_ptr_r + PW'(1);
    end
    if (rt_fall && !fall_through_mode)
      rd_ptr_nxt = '0;
    if (flush_any) begin
      rd_ptr_nxt = '0;
      wr_ptr_nxt = '0;
      b_out_nxt  = fmb_pkg::DATA_ZERO;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (a_fifo_wr && !fifo_full)
      mem_r[wr_ptr_r[AW-1:0]] <= a_data_s;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rd_ptr_r <= '0;
      wr_ptr_r <= '0;
      a_out_r  <= fmb_pkg::DATA_ZERO;
      b_out_r  <= fmb_pkg::DATA_ZERO;
      a_oe_r   <= 1'b0;
      b_oe_r   <= 1'b0;
    end else begin
      rd_ptr_r <= rd_ptr_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      a_out_r  <= a_out_nxt;
      b_out_r  <= b_out_nxt;
      a_oe_r   <= a_oe_nxt;
      b_oe_r   <= b_oe_nxt;
    end
  end

  assign o_port_a_data        = a_out_r;
  assign o_port_a_data_oe     = a_oe_r;
  assign o_port_b_data        = b_out_r;
  assign o_port_b_data_oe     = b_oe_r;
  assign o_a_to_b_mail_full_n = a2b_full_n_r;
  assign o_b_to_a_mail_full_n = b2a_full_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state, then the access completes
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        empty_n_r, full_n_r;
  logic [31:0] status_w, ptrs_w;
  logic        ctrl_hit;

  always_comb begin
    status_w = fmb_pkg::RD_ZERO;
    status_w[fmb_pkg::ST_A2B_FULL_N] = a2b_full_n_r;
    status_w[fmb_pkg::ST_B2A_FULL_N] = b2a_full_n_r;
    status_w[fmb_pkg::ST_EMPTY_N]    = ~fifo_empty;
    status_w[fmb_pkg::ST_FULL_N]     = ~fifo_full;
    status_w[fmb_pkg::ST_SERIAL_N]   = cfg_spm_n_r;
    status_w[fmb_pkg::ST_OFS_SEL +: 2] = cfg_fs_r;
    status_w[fmb_pkg::ST_WIDTH_EN]   = cfg_bm_r;
    status_w[fmb_pkg::ST_SIZE]       = (bw_code == fmb_pkg::BW_BYTE);
    status_w[fmb_pkg::ST_ORDER]      = cfg_be_r;
    status_w[fmb_pkg::ST_FALL_THROUGH_MODE]       = fall_through_mode;
    status_w[fmb_pkg::ST_RST_OK]     = rst_ok_r;
    status_w[fmb_pkg::ST_DEF_OFS +: 8] = def_ofs;
    ptrs_w = fmb_pkg::RD_ZERO;
    ptrs_w[fmb_pkg::PTR_RD +: PW] = rd_ptr_r;
    ptrs_w[fmb_pkg::PTR_WR +: PW] = wr_ptr_r;
  end

  assign ctrl_hit = i_avs_write & ~wait_r & (i_avs_address == fmb_pkg::REG_CTRL) & i_avs_byteenable[0];

  always_comb begin
    wait_nxt       = 1'b1;
    rdata_nxt      = rdata_r;
    soft_flush_nxt = ctrl_hit & i_avs_writedata[fmb_pkg::CTRL_FLUSH];
    if ((i_avs_read || i_avs_write) && wait_r) begin
      wait_nxt = 1'b0;
      case (i_avs_address)
        fmb_pkg::REG_STATUS: rdata_nxt = status_w;
        fmb_pkg::REG_PTRS:   rdata_nxt = ptrs_w;
        fmb_pkg::REG_MAIL:   rdata_nxt = a2b_mbx_r[31:0];
        default:             rdata_nxt = fmb_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wait_r       <= 1'b1;
      rdata_r      <= fmb_pkg::RD_ZERO;
      soft_flush_r <= 1'b0;
      empty_n_r    <= 1'b0;
      full_n_r     <= 1'b1;
    end else begin
      wait_r       <= wait_nxt;
      rdata_r      <= rdata_nxt;
      soft_flush_r <= soft_flush_nxt;
      empty_n_r    <= ~fifo_empty;
      full_n_r     <= ~fifo_full;
    end
  end

  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata    = rdata_r;
  assign o_fifo_empty_n    = empty_n_r;
  assign o_fifo_full_n     = full_n_r;
endmodule
`default_nettype wire

// ===== inc/fmb_pkg.sv
// Constants shared by the mailbox / reset / port control block
`default_nettype none
package fmb_pkg;
  // Data path widths
  localparam int unsigned LONG_W = 36;
  localparam int unsigned WORD_W = 18;
  localparam int unsigned BYTE_W = 9;
  localparam logic [35:0] MASK_LONG = 36'hFFFFFFFFF;
  localparam logic [35:0] MASK_WORD = 36'h00003FFFF;
  localparam logic [35:0] MASK_BYTE = 36'h0000001FF;

  // Port B bus width codes
  localparam logic [1:0] BW_LONG = 2'h0;
  localparam logic [1:0] BW_WORD = 2'h1;
  localparam logic [1:0] BW_BYTE = 2'h2;

  // Default flag offsets selected by the offset select pins
  localparam logic [7:0] OFS_NONE = 8'h00;
  localparam logic [7:0] OFS_8    = 8'h08;
  localparam logic [7:0] OFS_16   = 8'h10;
  localparam logic [7:0] OFS_64   = 8'h40;
  localparam logic [1:0] SEL_PAR  = 2'h0;
  localparam logic [1:0] SEL_8    = 2'h1;
  localparam logic [1:0] SEL_16   = 2'h2;

  // Edges of both port clocks needed while the main reset is held
  localparam logic [2:0] RST_EDGES = 3'h4;

  // Avalon register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PTRS   = 4'h8;
  localparam logic [3:0] REG_MAIL   = 4'hC;

  // Control register fields
  localparam int unsigned CTRL_FLUSH = 0;

  // Status register fields
  localparam int unsigned ST_A2B_FULL_N = 0;
  localparam int unsigned ST_B2A_FULL_N = 1;
  localparam int unsigned ST_EMPTY_N    = 2;
  localparam int unsigned ST_FULL_N     = 3;
  localparam int unsigned ST_SERIAL_N   = 4;
  localparam int unsigned ST_OFS_SEL    = 5;
  localparam int unsigned ST_WIDTH_EN   = 7;
  localparam int unsigned ST_SIZE       = 8;
  localparam int unsigned ST_ORDER      = 9;
  localparam int unsigned ST_FALL_THROUGH_MODE       = 10;
  localparam int unsigned ST_RST_OK     = 11;
  localparam int unsigned ST_DEF_OFS    = 16;

  // Pointer register fields
  localparam int unsigned PTR_RD = 0;
  localparam int unsigned PTR_WR = 16;

  // Reset values
  localparam logic [31:0] RD_ZERO   = 32'h00000000;
  localparam logic [35:0] DATA_ZERO = 36'h000000000;
endpackage
`default_nettype wire

// ===== hdl/fmb_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`default_nettype none
module fmb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk_sys, // System clock
  input  wire logic         i_rst,     // Synchronous reset, high
  input  wire logic [W-1:0] i_async,   // Pin levels
  output logic      [W-1:0] o_sync     // Synchronised levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  initial begin
    if (W < 1) $error("fmb_sync: W must be at least 1");
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule
`default_nettype wire

// ===== testbench/fmb_chk_assertions.sv
// Pin-level checks for the port control block
`default_nettype none
module fmb_chk (
  input wire logic i_clk_sys,            // Clock
  input wire logic i_rst,                // Reset
  input wire logic i_main_reset_n,       // Pin
  input wire logic i_mailbox_reset_n,    // Pin
  input wire logic i_flush_reset_n,      // Pin
  input wire logic i_port_a_dir,         // Pin
  input wire logic i_port_b_dir,         // Pin
  input wire logic i_port_b_select_n,    // Pin
  input wire logic i_port_a_mailbox_sel, // Pin
  input wire logic i_port_b_mailbox_sel, // Pin
  input wire logic i_avs_read,           // Bus
  input wire logic i_avs_write,          // Bus
  input wire logic o_port_a_data_oe,     // Drive
  input wire logic o_port_b_data_oe,     // Drive
  input wire logic o_a_to_b_mail_full_n, // Flag
  input wire logic o_b_to_a_mail_full_n, // Flag
  input wire logic o_avs_waitrequest     // Bus
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic rst_ok = i_main_reset_n & i_flush_reset_n;
  wire logic b_mb = ~i_port_b_select_n & i_port_b_mailbox_sel;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  chk_rst_flags: assert property (!$past(rst_ok, 3) && !$past(rst_ok, 4) |->
    o_a_to_b_mail_full_n && o_b_to_a_mail_full_n) else $error("Flag low in reset");
  chk_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("No answer");
  chk_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("Long answer");
  chk_a2b_set: assert property ($fell(o_a_to_b_mail_full_n) |->
    $past(i_port_a_dir && i_port_a_mailbox_sel, 2)) else $error("A2B flag fell");
  chk_b2a_set: assert property ($fell(o_b_to_a_mail_full_n) |->
    $past(~i_port_b_dir & b_mb, 2)) else $error("B2A flag fell");
  chk_b2a_clr: assert property ($rose(o_b_to_a_mail_full_n) |->
    $past(~i_port_a_dir & i_port_a_mailbox_sel | ~rst_ok | ~i_mailbox_reset_n | i_avs_write, 2))
    else $error("B2A flag rose");
  chk_a_oe: assert property (o_port_a_data_oe |-> !$past(i_port_a_dir, 3) || !$past(i_port_a_dir, 4))
    else $error("A drive");
  chk_b_oe: assert property (o_port_b_data_oe |->
    $past(i_port_b_dir & ~i_port_b_select_n, 3) || $past(i_port_b_dir & ~i_port_b_select_n, 4)) else $error("B drive");
  cov_a2b: cover property (!o_a_to_b_mail_full_n);
  cov_b2a: cover property (!o_b_to_a_mail_full_n);
  cov_bus: cover property (i_avs_write && !o_avs_waitrequest);
endmodule
bind fmb_port_ctrl fmb_chk chk_i (.*);
`default_nettype wire

// ===== testbench/fmb_port_peer.sv
// Far-side port master: one port clock pulse per request
`default_nettype none
module fmb_port_peer (
  input  wire logic i_clk_sys, // System clock
  input  wire logic i_go,      // Start an access
  output logic      o_pclk,    // Port clock pin
  output logic      o_done     // Access over
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r = 4'h0;
  logic [3:0] cnt_nxt;
  // Clock idles low; it goes high for four system cycles, eight cycles after the start
  always_comb cnt_nxt = (i_go || cnt_r != 4'h0) ? cnt_r + 4'h1 : cnt_r;
  always_ff @(posedge i_clk_sys) cnt_r <= cnt_nxt;
  assign o_pclk = cnt_r[3:2] == 2'h2;
  assign o_done = cnt_r == 4'hF;
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the port control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 1'h0, i_rst = 1'h1, i_main_reset_n = 1'h0, i_mailbox_reset_n = 1'h1, i_flush_reset_n = 1'h1;
  logic i_replay_strobe_n = 1'h1, i_port_a_en = 1'h0, i_port_b_en = 1'h0, i_port_b_select_n = 1'h0;
  logic i_port_a_dir = 1'h0, i_port_b_dir = 1'h1, i_port_a_mailbox_sel = 1'h0, i_port_b_mailbox_sel = 1'h0;
  logic i_width_match_en = 1'h1, i_bus_size_sel = 1'h0, i_byte_order_sel = 1'h0; // Static width
  logic i_serial_offset_load_n = 1'h1, i_avs_read = 1'h0, i_avs_write = 1'h0;
  logic [1:0] i_offset_sel = 2'h2, go = 2'h0;
  logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hF;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic [35:0] i_port_a_data = 36'h0, i_port_b_data = 36'h0, o_port_a_data, o_port_b_data;
  logic o_port_a_data_oe, o_port_b_data_oe, o_a_to_b_mail_full_n, o_b_to_a_mail_full_n;
  logic o_fifo_empty_n, o_fifo_full_n, o_avs_waitrequest;
  wire logic i_port_a_clk, i_port_b_clk;
  wire logic [1:0] done;
  int n_fail = 0, tests_run = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  fmb_port_ctrl dut (.*);
  fmb_port_peer pa (.i_clk_sys(i_clk_sys), .i_go(go[0]), .o_pclk(i_port_a_clk), .o_done(done[0]));
  fmb_port_peer pb (.i_clk_sys(i_clk_sys), .i_go(go[1]), .o_pclk(i_port_b_clk), .o_done(done[1]));
  ////////////////////////////////////////
  task automatic finish_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic to();
    n_fail++;
    finish_test();
  endtask
  task automatic acc(input bit p, input logic d, input logic m, input logic [35:0] v);
    int k;
    if (p) begin
      {i_port_b_dir, i_port_b_mailbox_sel, i_port_b_data} <= {d, m, v};
    end else begin
      {i_port_a_dir, i_port_a_mailbox_sel, i_port_a_data} <= {d, m, v};
    end
    go[p] <= 1'h1;
    tick(1);
    go[p] <= 1'h0;
    for (k = 0; k < 40 && done[p] !== 1'h1; k++) tick(1);
    {i_port_a_data, i_port_b_data} <= ~{i_port_a_data, i_port_b_data};
    tick(1);
    if (k == 40) to();
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int k;
    {i_avs_write, i_avs_read, i_avs_address, i_avs_writedata} <= {w, ~w, a, wd};
    for (k = 0; k < 20; k++) begin
      tick(1);
      if (o_avs_waitrequest === 1'h0) break;
    end
    rd = o_avs_readdata;
    {i_avs_write, i_avs_read} <= 2'h0;
    tick(1);
    if (k == 20) to();
  endtask
  ////////////////////////////////////////
  task automatic s_config();
    av(0, fmb_pkg::REG_STATUS, 32'h0);
    chk(rd[1:0], 2'h3);
    chk(rd[23:16], fmb_pkg::OFS_16);
    chk(rd[fmb_pkg::ST_SERIAL_N], 1'h1);
    chk(rd[fmb_pkg::ST_RST_OK], 1'h1);
    av(0, 4'h2, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic s_a2b();
    i_port_a_en <= 1'h0;
    acc(0, 1, 1, 36'h0000000FF);
    chk(o_a_to_b_mail_full_n, 1'h1);
    i_port_a_en <= 1'h1;
    acc(0, 1, 1, 36'h30001ABCD);
    chk(o_a_to_b_mail_full_n, 1'h0);
    acc(0, 1, 1, 36'h0AAAAAAAA);
    av(0, fmb_pkg::REG_MAIL, 32'h0);
    chk(rd, 32'h0001ABCD);
    acc(1, 1, 1, 36'h0);
    chk(o_port_b_data, 36'h00001ABCD);
    chk({o_a_to_b_mail_full_n, o_port_b_data_oe}, 2'h3);
  endtask
  task automatic s_b2a();
    i_port_b_select_n <= 1'h1;
    acc(1, 0, 1, 36'h0000000FF);
    chk(o_b_to_a_mail_full_n, 1'h1);
    i_port_b_select_n <= 1'h0;
    acc(1, 0, 0, 36'h000000055);
    chk({o_fifo_empty_n, o_fifo_full_n}, 2'h1);
    acc(1, 0, 1, 36'hFFFF2468A);
    chk(o_b_to_a_mail_full_n, 1'h0);
    acc(1, 0, 1, 36'h000011111);
    acc(0, 0, 1, 36'h0);
    chk(o_port_a_data, 36'h00002468A);
    chk({o_b_to_a_mail_full_n, o_port_a_data_oe}, 2'h3);
  endtask
  task automatic s_replay();
    acc(0, 1, 0, 36'h000000011);
    acc(0, 1, 0, 36'h000000022);
    acc(1, 1, 0, 36'h0);
    chk(o_port_b_data, 36'h000000011);
    acc(1, 1, 0, 36'h0);
    i_replay_strobe_n <= 1'h0;
    tick(8);
    i_replay_strobe_n <= 1'h1;
    tick(8);
    acc(1, 1, 0, 36'h0);
    chk(o_port_b_data, 36'h000000011);
    i_byte_order_sel <= 1'h1;
    tick(4);
    i_replay_strobe_n <= 1'h0;
    tick(8);
    {i_replay_strobe_n, i_byte_order_sel} <= 2'h2;
    tick(8);
    acc(1, 1, 0, 36'h0);
    chk(o_port_b_data, 36'h000000022);
    av(1, fmb_pkg::REG_CTRL, 32'h1);
    av(0, fmb_pkg::REG_PTRS, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic s_flush();
    acc(1, 0, 1, 36'h000000003);
    {i_offset_sel, i_flush_reset_n} <= 3'h2;
    tick(8);
    chk(o_b_to_a_mail_full_n, 1'h1);
    chk(o_port_b_data, 36'h0);
    i_flush_reset_n <= 1'h1;
    tick(8);
    av(0, fmb_pkg::REG_STATUS, 32'h0);
    chk(rd[23:16], fmb_pkg::OFS_16);
    acc(1, 0, 1, 36'h000000155);
    i_mailbox_reset_n <= 1'h0;
    tick(8);
    i_mailbox_reset_n <= 1'h1;
    tick(8);
    acc(0, 0, 1, 36'h0);
    chk(o_port_a_data, 36'h0);
  endtask
  initial begin
    tick(5);
    i_rst <= 1'h0;
    repeat (4) begin // Four edges of each port clock in main reset
      acc(0, 0, 0, 36'h0);
      acc(1, 1, 0, 36'h0);
    end
    {i_main_reset_n, i_port_a_en, i_port_b_en} <= 3'h7;
    tick(8);
    s_config();
    s_a2b();
    s_b2a();
    s_replay();
    s_flush();
    finish_test();
  end
endmodule
`default_nettype wire
